// *** hw/dtc_pin_sample.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sample #(
  parameter int W = 4
) (
  // Clock and control
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic         mstb,
  // Pins and samples
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_q, s1_d, s2_q, s2_d, smp_q, smp_d, prv_q, prv_d;

  always_comb begin
    s1_d  = pin;
    s2_d  = s1_q;
    smp_d = mstb ? s2_q : smp_q;
    prv_d = mstb ? smp_q : prv_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q  <= '0;
      s2_q  <= '0;
      smp_q <= '0;
      prv_q <= '0;
    end else if (ce) begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      smp_q <= smp_d;
      prv_q <= prv_d;
    end
  end

  // One sample per machine cycle, high then low marks a fall
  assign lvl  = smp_q;
  assign fall = prv_q & ~smp_q; // [R05]

  property p_sample_rate;
    @(posedge clk) disable iff (reset)
    ce && !mstb |=> $stable(lvl);
  endproperty
  a_sample_rate: assert property (p_sample_rate) else $error("sample moved off the machine cycle strobe"); // [R05]

endmodule
`default_nettype wire

// *** hw/dtc_pkg.sv ***
package dtc_pkg;

  typedef struct packed {
    logic       we;
    logic [2:0] idx;
    logic [7:0] wdata;
  } dtc_sfr_req_t;

  typedef struct packed {
    logic tf1;
    logic tf0;
    logic ie1;
    logic ie0;
  } dtc_evt_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ovf;
  } dtc_cnt_t;

endpackage

// *** hw/dtc_prescale.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtc_prescale (
  // Clock and control
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // Prescaler
  input  wire logic       en,
  input  wire logic [1:0] field,
  output logic            tick
);
  logic [1:0] cnt_q, cnt_d;

  // Tick after field+1 enabled machine cycles
  always_comb begin
    tick  = en && (cnt_q >= field); // [R01]
    cnt_d = cnt_q;
    if (en) begin
      cnt_d = tick ? 2'h0 : 2'(cnt_q + 2'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 2'h0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  property p_prescale_step;
    @(posedge clk) disable iff (reset)
    ce && en && !tick |=> cnt_q == 2'($past(cnt_q) + 2'h1);
  endproperty
  a_prescale_step: assert property (p_prescale_step) else $error("prescaler did not advance"); // [R01]

endmodule
`default_nettype wire

// *** hw/dtc_regs.svh ***
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

// Register indices on the special function register port
`define DTC_IDX_PRESCALE 3'h0
`define DTC_IDX_MODE     3'h1
`define DTC_IDX_CONTROL  3'h2
`define DTC_IDX_TL0      3'h3
`define DTC_IDX_TH0      3'h4
`define DTC_IDX_TL1      3'h5
`define DTC_IDX_TH1      3'h6

// Reset values
`define DTC_RST_PRESCALE 6'h3F
`define DTC_RST_MODE     8'h00
`define DTC_RST_COUNT    8'h00
`define DTC_RST_FLAGS    2'h0

// Control register bit positions
`define DTC_CTL_TF1 7
`define DTC_CTL_TR1 6
`define DTC_CTL_TF0 5
`define DTC_CTL_TR0 4
`define DTC_CTL_IE1 3
`define DTC_CTL_IT1 2
`define DTC_CTL_IE0 1
`define DTC_CTL_IT0 0

// Mode register nibble layout
`define DTC_MOD_GATE 3
`define DTC_MOD_CT   2

// Operating modes
`define DTC_MODE_13    2'h0
`define DTC_MODE_16    2'h1
`define DTC_MODE_8R    2'h2
`define DTC_MODE_SPLIT 2'h3

// Machine cycle length in system clocks
`define DTC_MCYC_CLKS 2'h3

`endif

// *** hw/dtc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"
// Contract
// (R01) Timer function advances every 1 to 4 machine cycles per prescale field.
// (R02) Machine cycle is three clocks, giving rates of clock over 3,6,9,12.
// (R03) Prescale fields reset to the slowest rate.
// (R04) Prescale bits 5:4 timer 1, 3:2 timer 0 high byte, 1:0 timer 0.
// (R05) Counter input sampled once per machine cycle; high then low counts.
// (R06) Count updates the machine cycle after the fall was seen.
// (R07) Counter/timer select picks pin when set; timer 1 upper nibble.
// (R08) Gate set: count only while interrupt pin and run bit high.
// (R09) Gate clear: count whenever run bit is high.
// (R10) Mode 0: 13-bit timer, low five bits prescale the high byte.
// (R11) Mode 1: 16-bit timer from high and low bytes.
// (R12) Mode 2: 8-bit low byte reloaded from high byte on overflow.
// (R13) Mode 3 stops timer 1 and splits timer 0 into two bytes.
// (R14) Overflow flags set by hardware, cleared by software or vectoring.
// (R15) Run bit starts the timer, clearing it stops counting.
// (R16) Trigger-type bit: falling edge when set, low level when clear.
// (R17) Edge flags set on edge, cleared by software or vectoring.
// (R18) Vectoring clears edge flags only; level flags follow the pin.
// (R19) Timer 1 in mode 3 holds its count.
// (R20) Split mode: high byte overflow drives the timer 1 flag.
// (R21) Machine-cycle strobe every three clocks times prescale and sampling.
module dtc_top (
  // Clock and control
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  input  wire logic                  CE,
  // Special function register port
  input  wire dtc_pkg::dtc_sfr_req_t SFR_REQ,
  output logic [7:0]                 SFR_RDATA,
  // Interrupt vectoring
  input  wire dtc_pkg::dtc_evt_t     VEC_ACK,
  output dtc_pkg::dtc_evt_t          IRQ_REQ,
  // Pins
  input  wire logic                  TIMER0_COUNT_PIN,
  input  wire logic                  TIMER1_COUNT_PIN,
  input  wire logic                  EXT_IRQ0_PIN,
  input  wire logic                  EXT_IRQ1_PIN
);
  import dtc_pkg::*;

  logic [1:0] mcnt_q, mcnt_d;
  logic       mstb;
  logic [5:0] pre_q, pre_d;
  logic [7:0] mod_q, mod_d;
  logic [1:0] tr_q, tr_d, it_q, it_d, tf_q, tf_d, ie_q, ie_d;
  logic [7:0] tl0_q, tl0_d, th0_q, th0_d, tl1_q, tl1_d, th1_q, th1_d;
  logic [7:0] rd_q, rd_d;
  logic [3:0] lvl, fall;
  logic [2:0] pen, ptick;
  logic [3:0] n0, n1;
  logic       run0, run1, split, inc0, inc_th0, inc1;
  logic       ovf0, ovf_th0, ovf1, wc;
  logic [8:0] th0s;
  logic [7:0] w;
  dtc_cnt_t   c0, c1;

  function automatic logic sfr_wr(input logic [2:0] idx);
    sfr_wr = SFR_REQ.we && (SFR_REQ.idx == idx);
  endfunction

  function automatic dtc_cnt_t step(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi);
    dtc_cnt_t   r;
    logic [16:0] s;
    r.lo  = lo;
    r.hi  = hi;
    r.ovf = 1'b0;
    s     = '0;
    case (m)
      `DTC_MODE_13: begin
        s     = 17'({4'h0, hi, lo[4:0]} + 17'h0_0001); // [R10]
        r.lo  = {lo[7:5], s[4:0]};
        r.hi  = s[12:5];
        r.ovf = s[13];
      end
      `DTC_MODE_16: begin
        s     = 17'({1'b0, hi, lo} + 17'h0_0001); // [R11]
        r.lo  = s[7:0];
        r.hi  = s[15:8];
        r.ovf = s[16];
      end
      `DTC_MODE_8R: begin
        s     = 17'({9'h000, lo} + 17'h0_0001);
        r.lo  = s[8] ? hi : s[7:0]; // [R12]
        r.ovf = s[8];
      end
      default: begin
        s     = 17'({9'h000, lo} + 17'h0_0001); // [R13]
        r.lo  = s[7:0];
        r.ovf = s[8];
      end
    endcase
    return r;
  endfunction

  // Machine-cycle strobe
  always_comb begin
    mstb   = (mcnt_q == 2'(`DTC_MCYC_CLKS - 2'h1)); // [R21] [R02]
    mcnt_d = mstb ? 2'h0 : 2'(mcnt_q + 2'h1);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      mcnt_q <= 2'h0;
    end else if (CE) begin
      mcnt_q <= mcnt_d;
    end
  end

  // Pin synchronisers and per-machine-cycle samples
  dtc_pin_sample #(
    .W(4)
  ) u_pins (
    .clk  (CLK),
    .reset(RESET),
    .ce   (CE),
    .mstb (mstb),
    .pin  ({EXT_IRQ1_PIN, EXT_IRQ0_PIN, TIMER1_COUNT_PIN, TIMER0_COUNT_PIN}),
    .lvl  (lvl),
    .fall (fall)
  );

  // Mode nibbles and count enables
  always_comb begin
    n0      = mod_q[3:0];
    n1      = mod_q[7:4]; // [R07]
    split   = (n0[1:0] == `DTC_MODE_SPLIT);
    run0    = tr_q[0] && (!n0[`DTC_MOD_GATE] || lvl[2]); // [R08] [R09] [R15]
    run1    = tr_q[1] && (!n1[`DTC_MOD_GATE] || lvl[3]); // [R08] [R09] [R15]
    pen[0]  = mstb && run0 && !n0[`DTC_MOD_CT];
    pen[1]  = mstb && split && tr_q[1];
    pen[2]  = mstb && run1 && !n1[`DTC_MOD_CT] && (n1[1:0] != `DTC_MODE_SPLIT);
    inc0    = mstb && run0 && (n0[`DTC_MOD_CT] ? fall[0] : ptick[0]); // [R07] [R06]
    inc_th0 = ptick[1]; // [R13]
    inc1    = mstb && run1 && (n1[1:0] != `DTC_MODE_SPLIT)
              && (n1[`DTC_MOD_CT] ? fall[1] : ptick[2]); // [R19] [R06]
  end

  // Prescalers: timer 0, timer 0 high byte, timer 1
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pre
      dtc_prescale u_pre (
        .clk  (CLK),
        .reset(RESET),
        .ce   (CE),
        .en   (pen[g]),
        .field(pre_q[2*g +: 2]), // [R04]
        .tick (ptick[g])
      );
    end
  endgenerate

  // Count registers
  always_comb begin
    c0      = step(n0[1:0], tl0_q, th0_q);
    c1      = step(n1[1:0], tl1_q, th1_q);
    th0s    = 9'({1'b0, th0_q} + 9'h001);
    ovf0    = inc0 && c0.ovf;
    ovf_th0 = inc_th0 && th0s[8];
    ovf1    = inc1 && c1.ovf;
    tl0_d   = tl0_q;
    th0_d   = th0_q;
    tl1_d   = tl1_q;
    th1_d   = th1_q;
    if (inc0) begin
      tl0_d = c0.lo;
      if (!split) begin
        th0_d = c0.hi;
      end
    end
    if (inc_th0) begin
      th0_d = th0s[7:0];
    end
    if (inc1) begin
      tl1_d = c1.lo;
      th1_d = c1.hi;
    end
    if (sfr_wr(`DTC_IDX_TL0)) begin
      tl0_d = SFR_REQ.wdata;
    end
    if (sfr_wr(`DTC_IDX_TH0)) begin
      th0_d = SFR_REQ.wdata;
    end
    if (sfr_wr(`DTC_IDX_TL1)) begin
      tl1_d = SFR_REQ.wdata;
    end
    if (sfr_wr(`DTC_IDX_TH1)) begin
      th1_d = SFR_REQ.wdata;
    end
  end

  // Configuration and flags; hardware set wins over any clear
  always_comb begin
    w     = SFR_REQ.wdata;
    wc    = sfr_wr(`DTC_IDX_CONTROL);
    pre_d = sfr_wr(`DTC_IDX_PRESCALE) ? w[5:0] : pre_q;
    mod_d = sfr_wr(`DTC_IDX_MODE) ? w : mod_q;
    tr_d  = wc ? {w[`DTC_CTL_TR1], w[`DTC_CTL_TR0]} : tr_q;
    it_d  = wc ? {w[`DTC_CTL_IT1], w[`DTC_CTL_IT0]} : it_q;
    tf_d  = wc ? {w[`DTC_CTL_TF1], w[`DTC_CTL_TF0]} : (tf_q & ~{VEC_ACK.tf1, VEC_ACK.tf0}); // [R14]
    tf_d[0] = tf_d[0] | ovf0; // [R14]
    tf_d[1] = tf_d[1] | (split ? ovf_th0 : ovf1); // [R20]
    ie_d  = wc ? {w[`DTC_CTL_IE1], w[`DTC_CTL_IE0]} : (ie_q & ~{VEC_ACK.ie1, VEC_ACK.ie0}); // [R17]
    for (int i = 0; i < 2; i++) begin
      if (it_q[i]) begin
        ie_d[i] = ie_d[i] | (mstb && fall[2+i]); // [R16] [R17]
      end else begin
        ie_d[i] = !lvl[2+i]; // [R16] [R18]
      end
    end
  end

  // Register read data
  always_comb begin
    case (SFR_REQ.idx)
      `DTC_IDX_PRESCALE: rd_d = {2'b00, pre_q};
      `DTC_IDX_MODE:     rd_d = mod_q;
      `DTC_IDX_CONTROL:  rd_d = {tf_q[1], tr_q[1], tf_q[0], tr_q[0], ie_q[1], it_q[1], ie_q[0], it_q[0]};
      `DTC_IDX_TL0:      rd_d = tl0_q;
      `DTC_IDX_TH0:      rd_d = th0_q;
      `DTC_IDX_TL1:      rd_d = tl1_q;
      `DTC_IDX_TH1:      rd_d = th1_q;
      default:           rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pre_q <= `DTC_RST_PRESCALE; // [R03]
      mod_q <= `DTC_RST_MODE;
      tr_q  <= `DTC_RST_FLAGS;
      it_q  <= `DTC_RST_FLAGS;
      tf_q  <= `DTC_RST_FLAGS;
      ie_q  <= `DTC_RST_FLAGS;
      tl0_q <= `DTC_RST_COUNT;
      th0_q <= `DTC_RST_COUNT;
      tl1_q <= `DTC_RST_COUNT;
      th1_q <= `DTC_RST_COUNT;
      rd_q  <= 8'h00;
    end else if (CE) begin
      pre_q <= pre_d;
      mod_q <= mod_d;
      tr_q  <= tr_d;
      it_q  <= it_d;
      tf_q  <= tf_d;
      ie_q  <= ie_d;
      tl0_q <= tl0_d;
      th0_q <= th0_d;
      tl1_q <= tl1_d;
      th1_q <= th1_d;
      rd_q  <= rd_d;
    end
  end

  assign SFR_RDATA = rd_q;
  assign IRQ_REQ   = '{tf1: tf_q[1], tf0: tf_q[0], ie1: ie_q[1], ie0: ie_q[0]};

  property p_mcycle;
    @(posedge CLK) disable iff (RESET || !CE)
    mstb |=> !mstb ##1 !mstb ##1 mstb;
  endproperty
  a_mcycle: assert property (p_mcycle) else $error("machine cycle strobe not every three clocks"); // [R21]

  property p_reset_pre;
    @(posedge CLK)
    $past(RESET) && !RESET |-> pre_q == `DTC_RST_PRESCALE;
  endproperty
  a_reset_pre: assert property (p_reset_pre) else $error("prescale not slowest after reset"); // [R03]

  property p_gate0;
    @(posedge CLK) disable iff (RESET)
    n0[`DTC_MOD_GATE] && !lvl[2] |-> !inc0;
  endproperty
  a_gate0: assert property (p_gate0) else $error("timer 0 counted with gate pin low"); // [R08]

  property p_run0;
    @(posedge CLK) disable iff (RESET)
    !tr_q[0] |-> !inc0 && !pen[0];
  endproperty
  a_run0: assert property (p_run0) else $error("timer 0 counted with run bit clear"); // [R15]

  property p_tf0;
    @(posedge CLK) disable iff (RESET)
    CE && ovf0 |=> tf_q[0];
  endproperty
  a_tf0: assert property (p_tf0) else $error("overflow did not set timer 0 flag"); // [R14]

  property p_tf1_split;
    @(posedge CLK) disable iff (RESET)
    CE && split && ovf_th0 |=> tf_q[1];
  endproperty
  a_tf1_split: assert property (p_tf1_split) else $error("high byte overflow missed timer 1 flag"); // [R20]

  property p_reload;
    @(posedge CLK) disable iff (RESET)
    CE && inc0 && n0[1:0] == `DTC_MODE_8R && c0.ovf && !sfr_wr(`DTC_IDX_TL0) |=> tl0_q == $past(th0_q);
  endproperty
  a_reload: assert property (p_reload) else $error("low byte not reloaded from high byte"); // [R12]

  property p_t1_hold;
    @(posedge CLK) disable iff (RESET)
    CE && n1[1:0] == `DTC_MODE_SPLIT && !sfr_wr(`DTC_IDX_TL1) && !sfr_wr(`DTC_IDX_TH1)
      |=> $stable({tl1_q, th1_q});
  endproperty
  a_t1_hold: assert property (p_t1_hold) else $error("timer 1 moved in mode 3"); // [R19]

  property p_level;
    @(posedge CLK) disable iff (RESET)
    CE && !it_q[0] |=> ie_q[0] == !$past(lvl[2]);
  endproperty
  a_level: assert property (p_level) else $error("level flag does not follow the pin"); // [R18]

  property p_edge_ack;
    @(posedge CLK) disable iff (RESET)
    CE && it_q[0] && VEC_ACK.ie0 && !(mstb && fall[2]) && !wc |=> !ie_q[0];
  endproperty
  a_edge_ack: assert property (p_edge_ack) else $error("edge flag not cleared on vectoring"); // [R17]

endmodule
`default_nettype wire

// *** verification/dtc_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  // Clock
  input  wire logic       clk,
  // Pins toward the block
  output logic      [1:0] count_pin,
  output logic      [1:0] irq_pin
);
  initial begin
    count_pin = 2'h3;
    irq_pin   = 2'h3;
  end
  // Falling pulses, each level held for at least one machine cycle
  task automatic pulse(input int unsigned t, input int unsigned n, input int unsigned hold);
    repeat (n) begin
      repeat (hold) @(posedge clk);
      #1 count_pin[t] = 1'b0;
      repeat (hold) @(posedge clk);
      #1 count_pin[t] = 1'b1;
    end
  endtask
  // Interrupt and gate pin level
  task automatic irq(input int unsigned t, input logic v);
    irq_pin[t] = v;
  endtask
endmodule
`default_nettype wire

// *** verification/test_dtc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_dtc_top;
  import dtc_pkg::*;
  logic         clk;
  logic         reset;
  dtc_sfr_req_t sfr;
  logic [7:0]   rdata;
  dtc_evt_t     vec;
  dtc_evt_t     irq;
  logic [1:0]   cpin;
  logic [1:0]   ipin;
  int           err_count;
  int           cmp_count;
  int           seed;
  int           n;
  logic [7:0]   a;
  logic [7:0]   b;
  logic [7:0]   r;

  dtc_top uut (.CLK(clk), .RESET(reset), .CE(1'b1), .SFR_REQ(sfr), .SFR_RDATA(rdata), .VEC_ACK(vec),
    .IRQ_REQ(irq), .TIMER0_COUNT_PIN(cpin[0]), .TIMER1_COUNT_PIN(cpin[1]), .EXT_IRQ0_PIN(ipin[0]),
    .EXT_IRQ1_PIN(ipin[1]));
  dtc_pin_model pm (.clk(clk), .count_pin(cpin), .irq_pin(ipin));

  always #5 clk = ~clk;

  task automatic idle(input int k);
    sfr.we = 1'b0;
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    sfr = '{1'b1, idx, d};
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [2:0] idx, output logic [7:0] d);
    sfr = '{1'b0, idx, 8'h00};
    @(posedge clk);
    #1;
    d = rdata;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ack(input int fb);
    vec = dtc_evt_t'(4'h1 << fb);
    idle(1);
    vec = '0;
  endtask
  task automatic moves(input logic exp, input string what);
    idle(8);
    rd(3'h3, a);
    idle(24);
    rd(3'h3, b);
    chk(what, {7'h00, exp}, {7'h00, a !== b});
  endtask
  task automatic period(input int exp);
    int c;
    rd(3'h3, b);
    c = 0;
    for (int k = 0; k < 2; k++) begin
      c = 0;
      a = b;
      while (a === b && c < 40) begin
        rd(3'h3, b);
        c++;
      end
    end
    chk("tick period", exp[7:0], c[7:0]);
  endtask
  task automatic ovf(input logic [7:0] md, input logic [7:0] tl, input logic [7:0] th, input logic [7:0] ctl,
                     input logic [2:0] ri, input logic [7:0] exp, input int fb);
    int c;
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h1, md);
    for (int i = 3; i < 7; i++) wr(i[2:0], i[0] ? tl : th);
    wr(3'h2, ctl);
    c = 0;
    while (irq[fb] !== 1'b1 && c < 20) begin
      idle(1);
      c++;
    end
    chk("overflow flag", 8'h01, {7'h00, irq[fb]});
    ack(fb);
    chk("flag after vectoring", 8'h00, {7'h00, irq[fb]});
    wr(3'h2, 8'h00);
    rd(ri, a);
    chk("count after overflow", exp, a);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    sfr = '0;
    vec = '0;
    err_count = 0;
    cmp_count = 0;
    seed = 32'h2b04;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    idle(20);
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], a);
      chk("reset value", (i == 0) ? 8'h3F : 8'h00, a);
    end
    $display("reset values done");
    wr(3'h0, 8'hFF);
    rd(3'h0, a);
    chk("prescale reserved bits", 8'h3F, a);
    wr(3'h1, 8'h01);
    wr(3'h2, 8'h10);
    for (int f = 0; f < 4; f++) begin
      wr(3'h0, 8'h3C | f[7:0]);
      period(3 * (f + 1));
    end
    $display("prescale done");
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h09);
    pm.irq(0, 1'b0);
    moves(1'b0, "gate closed");
    pm.irq(0, 1'b1);
    moves(1'b1, "gate open");
    pm.irq(0, 1'b0);
    wr(3'h1, 8'h01);
    moves(1'b1, "gate off");
    wr(3'h2, 8'h00);
    moves(1'b0, "run cleared");
    pm.irq(0, 1'b1);
    $display("gate done");
    ovf(8'h00, 8'hFF, 8'hFF, 8'h10, 3'h3, 8'hE0, 2);
    ovf(8'h01, 8'hFF, 8'hFF, 8'h10, 3'h3, 8'h00, 2);
    ovf(8'h02, 8'hFF, 8'hA5, 8'h10, 3'h3, 8'hA5, 2);
    r = $random(seed);
    ovf(8'h33, r, 8'hFF, 8'h40, 3'h5, r, 3);
    $display("modes done");
    wr(3'h1, 8'h51);
    wr(3'h5, 8'h00);
    wr(3'h2, 8'h40);
    rd(3'h1, a);
    chk("mode readback", 8'h51, a);
    rd(3'h5, a);
    idle(30);
    rd(3'h5, b);
    chk("counter without falls", a, b);
    n = 1 + ($random(seed) & 15);
    pm.pulse(1, n, 4 + ($random(seed) & 3));
    idle(15);
    rd(3'h5, a);
    chk("counted falls", n[7:0], a);
    $display("counter done");
    wr(3'h2, 8'h04);
    idle(10);
    chk("edge flag idle", 8'h00, {7'h00, irq.ie1});
    pm.irq(1, 1'b0);
    idle(12);
    chk("edge flag set", 8'h01, {7'h00, irq.ie1});
    pm.irq(1, 1'b1);
    ack(1);
    chk("edge flag vectored", 8'h00, {7'h00, irq.ie1});
    wr(3'h2, 8'h00);
    pm.irq(1, 1'b0);
    idle(12);
    ack(1);
    chk("level flag held", 8'h01, {7'h00, irq.ie1});
    pm.irq(1, 1'b1);
    idle(12);
    chk("level flag follows pin", 8'h00, {7'h00, irq.ie1});
    $display("external interrupt done");
    report_and_stop();
  end
endmodule
`default_nettype wire
